// File: pasl_board_model.sv
// Board model: strap resistors and status LEDs on shared pins
`timescale 1ns/1ps
`default_nettype none
module pasl_board_model (
	input wire logic [2:0] pullLevel,
	input wire logic [2:0] pinOut,
	input wire logic [2:0] pinOe,
	output logic [2:0] pinLevel,
	output logic [2:0] ledOn
);
	// ====
	// Pin levels
	// Resistor sets every undriven pin
	assign pinLevel = (pinOe & pinOut) | (~pinOe & pullLevel);
	// LED lit only when pin is pulled off its resistor level
	assign ledOn = pinLevel ^ pullLevel;
endmodule
`default_nettype wire

// File: pasl_pkg.sv
// Package with constants for the address strap and status LED block
package pasl_pkg;
	// ==========================================
	// Strap pins and address layout
	localparam int STRAP_COUNT = 3;
	localparam int ADDR_WIDTH = 5;
	localparam int ADDR_BIT_LINK = 2;
	localparam int ADDR_BIT_TX = 3;
	localparam int ADDR_BIT_RX = 4;
	localparam int IDX_LINK = 0;
	localparam int IDX_TX = 1;
	localparam int IDX_RX = 2;
	localparam logic [1:0] LOW_ADDR_DEFAULT = 2'h0;
	// ==========================================
	// Reset values
	localparam logic [STRAP_COUNT-1:0] STRAP_RESET = 3'h0;
	localparam logic [STRAP_COUNT-1:0] SYNC_RESET = 3'h0;
	// ==========================================
	// Phase of the shared pins, Gray coded
	typedef enum logic [1:0] {
		PASL_SAMPLE = 2'h0,
		PASL_CAPTURE = 2'h1,
		PASL_DRIVE = 2'h3
	} pasl_phase_t;
endpackage

// File: pasl_strap_led.sv
// Shared address strap and status LED pins with speed indication
`timescale 1ns/1ps
`default_nettype none
module pasl_strap_led
	import pasl_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic softReset,
	input wire logic linkUp,
	input wire logic txActive,
	input wire logic rxActive,
	input wire logic speed100,
	input wire logic [pasl_pkg::STRAP_COUNT-1:0] strapPinIn,
	output logic [pasl_pkg::STRAP_COUNT-1:0] strapPinOut,
	output logic [pasl_pkg::STRAP_COUNT-1:0] strapPinOe,
	output logic [pasl_pkg::ADDR_WIDTH-1:0] phyAddr,
	output logic addrValid,
	output logic speedSelectOut
);
	// ==========================================
	// Declarations
	// Pin synchroniser stages, first read only by the second
	logic [STRAP_COUNT-1:0] pinSync1_reg;
	logic [STRAP_COUNT-1:0] pinSync2_reg;
	logic [STRAP_COUNT-1:0] pinSync3_reg;
	// Strap levels latched at reset exit
	logic [STRAP_COUNT-1:0] strap_reg;
	logic [STRAP_COUNT-1:0] strap_next;
	// Phase of the shared pins
	pasl_phase_t phase_reg;
	pasl_phase_t phase_next;
	// Status gathered in pin order
	wire [STRAP_COUNT-1:0] statusVec;
	wire [STRAP_COUNT-1:0] ledNext;
	wire driving;
	wire captureNow;

	// ==========================================
	// Input synchroniser
	// Three stages; the strap is taken once stages two and three agree
	// No reset here on purpose: a cleared chain would agree on zeros and
	// be captured; free running, it has settled by the time reset lifts
	// Pins are inputs and sampled during reset
	always_ff @(posedge clock) begin
		pinSync1_reg <= strapPinIn;
		pinSync2_reg <= pinSync1_reg;
		pinSync3_reg <= pinSync2_reg;
	end

	// ==========================================
	// Phase sequencing
	// Reset pin holds sampling phase
	// Sample phase lasts one cycle after release; the synchroniser has already filled during reset
	assign captureNow = (phase_reg == PASL_CAPTURE) && (pinSync2_reg == pinSync3_reg);
	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			PASL_SAMPLE: begin
				phase_next = PASL_CAPTURE;
			end
			PASL_CAPTURE: begin
				// Wait for two stable stages before taking the strap
				if (captureNow) begin
					phase_next = PASL_DRIVE;
				end
			end
			PASL_DRIVE: begin
				// Stays here; software reset never returns to sampling
				phase_next = PASL_DRIVE;
			end
			default: begin
				phase_next = PASL_SAMPLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= PASL_SAMPLE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	// ==========================================
	// Strap capture
	// Capture once at reset exit
	// Level maps straight to the bit
	assign strap_next = captureNow ? pinSync3_reg : strap_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strap_reg <= STRAP_RESET;
		end else begin
			strap_reg <= strap_next;
		end
	end

	// ==========================================
	// LED drive
	// Link status on link pin
	assign statusVec[IDX_LINK] = linkUp;
	assign statusVec[IDX_TX] = txActive;
	assign statusVec[IDX_RX] = rxActive;
	// Asserted level is inverse of strap
	assign ledNext = statusVec ^ strap_reg;
	assign driving = (phase_reg == PASL_DRIVE);

	// Outputs registered; softReset is deliberately unused here so the
	// pins keep driving through it
	// Software reset leaves pins as outputs
	// Follows status one cycle later, no stretch
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strapPinOut <= STRAP_RESET;
			strapPinOe <= STRAP_RESET;
			speedSelectOut <= 1'b0;
		end else begin
			strapPinOut <= driving ? ledNext : STRAP_RESET;
			strapPinOe <= {STRAP_COUNT{driving}};
			// Low for 10M, high for 100M
			speedSelectOut <= speed100;
		end
	end

	// ==========================================
	// Address output
	// Strap bits placed at address bits two to four
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phyAddr <= '0;
			addrValid <= 1'b0;
		end else begin
			phyAddr[ADDR_BIT_LINK] <= strap_next[IDX_LINK];
			phyAddr[ADDR_BIT_TX] <= strap_next[IDX_TX];
			phyAddr[ADDR_BIT_RX] <= strap_next[IDX_RX];
			phyAddr[ADDR_BIT_LINK-1:0] <= LOW_ADDR_DEFAULT;
			addrValid <= driving | captureNow;
		end
	end

	// ==========================================
	// Assertions
	// LED level against strap
	led_inverts_a: assert property (@(posedge clock) disable iff (!rst_n)
		(driving && $past(driving)) |=> strapPinOut == ($past(statusVec) ^ strap_reg))
		else $error("LED level not inverse of strap");
	pins_stay_out_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(addrValid) |=> (&strapPinOe)[*8])
		else $error("Pins released after capture");
	addr_matches_a: assert property (@(posedge clock) disable iff (!rst_n)
		addrValid |-> phyAddr[ADDR_BIT_LINK] == strap_reg[IDX_LINK])
		else $error("Address bit two wrong");
	addr_tx_a: assert property (@(posedge clock) disable iff (!rst_n)
		addrValid |-> phyAddr[ADDR_BIT_TX] == strap_reg[IDX_TX])
		else $error("Address bit three wrong");
	addr_rx_a: assert property (@(posedge clock) disable iff (!rst_n)
		addrValid |-> phyAddr[ADDR_BIT_RX] == strap_reg[IDX_RX])
		else $error("Address bit four wrong");
	strap_map_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(addrValid) |-> phyAddr[ADDR_BIT_RX:ADDR_BIT_LINK] == $past(pinSync3_reg))
		else $error("Address not equal to strap levels");
	strap_frozen_a: assert property (@(posedge clock) disable iff (!rst_n)
		$past(driving) |-> $stable(strap_reg))
		else $error("Strap changed after capture");
	valid_holds_a: assert property (@(posedge clock) disable iff (!rst_n)
		addrValid |=> addrValid)
		else $error("Address valid dropped");
	no_drive_early_a: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(driving) |-> strapPinOe == STRAP_RESET)
		else $error("Pins driven during sampling");
	speed_follows_a: assert property (@(posedge clock) disable iff (!rst_n)
		speed100 |=> speedSelectOut)
		else $error("Speed output not high for 100M");
	speed_low_a: assert property (@(posedge clock) disable iff (!rst_n)
		!speed100 |=> !speedSelectOut)
		else $error("Speed output not low for 10M");
	link_led_a: assert property (@(posedge clock) disable iff (!rst_n)
		(driving && linkUp) |=> strapPinOut[IDX_LINK] == !strap_reg[IDX_LINK])
		else $error("Link LED not asserted");
	// Link LED drops with no stretch
	link_off_a: assert property (@(posedge clock) disable iff (!rst_n)
		(driving && !linkUp) |=> strapPinOut[IDX_LINK] == strap_reg[IDX_LINK])
		else $error("Link LED stretched past status");
	tx_led_a: assert property (@(posedge clock) disable iff (!rst_n)
		(driving && txActive) |=> strapPinOut[IDX_TX] == !strap_reg[IDX_TX])
		else $error("Transmit LED not asserted");
	rx_led_a: assert property (@(posedge clock) disable iff (!rst_n)
		(driving && rxActive) |=> strapPinOut[IDX_RX] == !strap_reg[IDX_RX])
		else $error("Receive LED not asserted");
endmodule
`default_nettype wire

// File: tb_phy_address_strap_status_led.sv
// Testbench for the strap and status LED block
`timescale 1ns/1ps
`default_nettype none
module tb_phy_address_strap_status_led;
	logic clock = 1'b0, rst_n = 1'b0, softReset = 1'b0, speed100 = 1'b0;
	logic linkUp = 1'b0, txActive = 1'b0, rxActive = 1'b0;
	logic [2:0] pull = 3'h0;
	wire logic [2:0] pinLevel, ledOn, pinOut, pinOe;
	wire logic [4:0] phyAddr;
	wire logic addrValid, speedSelectOut;
	int mismatches = 0, checkCount = 0;
	// ====
	// Clock, 8 ns; stands in for the reference
	initial begin
		forever #4 clock = ~clock;
	end
	pasl_strap_led dut (.clock(clock), .rst_n(rst_n), .softReset(softReset), .linkUp(linkUp),
		.txActive(txActive), .rxActive(rxActive), .speed100(speed100), .strapPinIn(pinLevel),
		.strapPinOut(pinOut), .strapPinOe(pinOe), .phyAddr(phyAddr), .addrValid(addrValid),
		.speedSelectOut(speedSelectOut));
	pasl_board_model board (.pullLevel(pull), .pinOut(pinOut), .pinOe(pinOe),
		.pinLevel(pinLevel), .ledOn(ledOn));
	// ====
	// Shared tasks: one compare per kind of result
	task automatic compare_addr(input logic [4:0] got, input logic [4:0] exp);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: address %h expected %h", $time, got, exp);
		end
	endtask
	task automatic compare_pins(input logic [2:0] got, input logic [2:0] exp);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: pins %b expected %b", $time, got, exp);
		end
	endtask
	task automatic compare_bit(input logic got, input logic exp);
		checkCount++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic printVerdict();
		if (mismatches == 0 && checkCount > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Hardware reset with a strap pattern, bounded wait for capture
	task automatic reset_capture(input logic [2:0] strap);
		int n;
		@(negedge clock);
		rst_n = 1'b0;
		pull = strap;
		repeat (8) @(negedge clock);
		compare_bit(addrValid, 1'b0);
		compare_pins(pinOe, 3'h0);
		compare_bit(speedSelectOut, 1'b0);
		compare_addr(phyAddr, 5'h00);
		rst_n = 1'b1;
		n = 0;
		while (addrValid !== 1'b1 && n < 12) begin
			@(negedge clock);
			n++;
		end
		if (n == 12) begin
			mismatches++;
			$display("mismatch at %0t: no capture", $time);
			printVerdict();
		end else begin
			compare_addr(phyAddr, {strap, 2'h0});
			compare_pins(pinOe, 3'h0);
			@(negedge clock);
			compare_pins(pinOe, 3'h7);
		end
	endtask
	// Status in, LEDs and speed out one cycle later
	task automatic led_check(input logic [2:0] status);
		@(negedge clock);
		{rxActive, txActive, linkUp} = status;
		speed100 = status[0];
		@(negedge clock);
		compare_pins(ledOn, status);
		compare_pins(pinOut, status ^ pull);
		compare_bit(speedSelectOut, status[0]);
	endtask
	// Software reset must leave address and drive alone
	task automatic soft_reset_check(input logic [2:0] strap);
		@(negedge clock);
		softReset = 1'b1;
		repeat (3) @(negedge clock);
		compare_addr(phyAddr, {strap, 2'h0});
		compare_pins(pinOe, 3'h7);
		compare_bit(addrValid, 1'b1);
		led_check(3'h5);
		softReset = 1'b0;
	endtask
	// One hardware reset with a strap, then LEDs and software reset
	task automatic strap_round(input logic [2:0] strap);
		reset_capture(strap);
		led_check(3'h7);
		led_check(~strap);
		led_check(3'h0);
		soft_reset_check(strap);
	endtask
	// ====
	// Main sequence, mid-run resets with several straps
	initial begin
		strap_round(3'h5);
		strap_round(3'h2);
		strap_round(3'h7);
		strap_round(3'h0);
		printVerdict();
	end
endmodule
`default_nettype wire
